//--- hw/cfir_pkg.sv
/*
 * Shared constants for the complex FIR filter: word widths, tap counts,
 * pipeline latency and reset values.
 * Assumes a single synchronous clock domain and signed two's complement data.
 */
package cfir_pkg;

    localparam int WORD_W_WIDE    = 18;
    localparam int WORD_W_NARROW  = 9;
    localparam int TAPS_PER_WIDE  = 1;
    localparam int TAPS_PER_NARR  = 2;
    localparam int NUM_SLICES     = 4;
    localparam int NUM_TAPS       = NUM_SLICES * TAPS_PER_WIDE;
    localparam int PROD_W         = 2 * WORD_W_WIDE + 1;
    localparam int SUM_W          = PROD_W + 3;
    localparam int IDX_W          = 2;
    localparam int LATENCY        = 4;

    localparam logic [WORD_W_WIDE-1:0] COEF_RESET = 18'h00000;
    localparam logic [SUM_W-1:0]       SUM_RESET  = 40'h0000000000;

endpackage

//--- hw/complex_fir_filter.sv
/*
 * Complex FIR filter datapath built from multiply-add slices.
 * Each slice holds one 18-bit complex tap, or two 9-bit taps when
 * narrow_mode is set. Slice results are summed outside the slices.
 * Assumes upstream presents samples with in_valid and downstream
 * always accepts results; coefficient loaders follow the load ports.
 */
`timescale 1ns/1ps

module cfir_slice (
    input  wire logic                                   clk_sys,
    input  wire logic                                   reset,
    input  wire logic                                   narrow_mode,
    input  wire logic signed [cfir_pkg::WORD_W_WIDE-1:0] x_re,
    input  wire logic signed [cfir_pkg::WORD_W_WIDE-1:0] x_im,
    input  wire logic signed [cfir_pkg::WORD_W_WIDE-1:0] h_re,
    input  wire logic signed [cfir_pkg::WORD_W_WIDE-1:0] h_im,
    output logic signed      [cfir_pkg::PROD_W-1:0]      y_re_q,
    output logic signed      [cfir_pkg::PROD_W-1:0]      y_im_q
);
    localparam int N = cfir_pkg::WORD_W_NARROW;
    logic signed [cfir_pkg::PROD_W-1:0] y_re_d;
    logic signed [cfir_pkg::PROD_W-1:0] y_im_d;
    logic signed [2*N:0]                n_re0;
    logic signed [2*N:0]                n_im0;
    logic signed [2*N:0]                n_re1;
    logic signed [2*N:0]                n_im1;
    logic signed [N-1:0]                lo_x_re;
    logic signed [N-1:0]                lo_x_im;
    logic signed [N-1:0]                lo_h_re;
    logic signed [N-1:0]                lo_h_im;
    logic signed [N-1:0]                hi_x_re;
    logic signed [N-1:0]                hi_x_im;
    logic signed [N-1:0]                hi_h_re;
    logic signed [N-1:0]                hi_h_im;

    // Narrow mode packs two 9-bit taps into the high and low halves.
    // A part-select is unsigned, so each half is first held as a signed word.
    always_comb begin
        lo_x_re = x_re[N-1:0];
        lo_x_im = x_im[N-1:0];
        lo_h_re = h_re[N-1:0];
        lo_h_im = h_im[N-1:0];
        hi_x_re = x_re[2*N-1:N];
        hi_x_im = x_im[2*N-1:N];
        hi_h_re = h_re[2*N-1:N];
        hi_h_im = h_im[2*N-1:N];
        n_re0 = (2*N+1)'(lo_x_re * lo_h_re)
              - (2*N+1)'(lo_x_im * lo_h_im);
        n_im0 = (2*N+1)'(lo_x_re * lo_h_im)
              + (2*N+1)'(lo_h_re * lo_x_im);
        n_re1 = (2*N+1)'(hi_x_re * hi_h_re)
              - (2*N+1)'(hi_x_im * hi_h_im);
        n_im1 = (2*N+1)'(hi_x_re * hi_h_im)
              + (2*N+1)'(hi_h_re * hi_x_im);
        if (narrow_mode) begin
            y_re_d = cfir_pkg::PROD_W'(n_re0 + n_re1);
            y_im_d = cfir_pkg::PROD_W'(n_im0 + n_im1);
        end else begin
            y_re_d = cfir_pkg::PROD_W'(x_re * h_re)
                   - cfir_pkg::PROD_W'(x_im * h_im);
            y_im_d = cfir_pkg::PROD_W'(x_re * h_im)
                   + cfir_pkg::PROD_W'(h_re * x_im);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            y_re_q <= '0;
            y_im_q <= '0;
        end else begin
            y_re_q <= y_re_d;
            y_im_q <= y_im_d;
        end
    end

    AST_NARROW_REAL: assert property (
        @(posedge clk_sys) disable iff (reset)
        narrow_mode |=> y_re_q == cfir_pkg::PROD_W'(
            $past($signed(x_re[N-1:0])) * $past($signed(h_re[N-1:0]))
          - $past($signed(x_im[N-1:0])) * $past($signed(h_im[N-1:0]))
          + $past($signed(x_re[2*N-1:N])) * $past($signed(h_re[2*N-1:N]))
          - $past($signed(x_im[2*N-1:N])) * $past($signed(h_im[2*N-1:N]))))
        else $error("Narrow slice real sum wrong.");

    AST_NARROW_IMAG: assert property (
        @(posedge clk_sys) disable iff (reset)
        narrow_mode |=> y_im_q == cfir_pkg::PROD_W'(
            $past($signed(x_re[N-1:0])) * $past($signed(h_im[N-1:0]))
          + $past($signed(h_re[N-1:0])) * $past($signed(x_im[N-1:0]))
          + $past($signed(x_re[2*N-1:N])) * $past($signed(h_im[2*N-1:N]))
          + $past($signed(h_re[2*N-1:N])) * $past($signed(x_im[2*N-1:N]))))
        else $error("Narrow slice imaginary sum wrong.");
endmodule

// Operation
// - Each tap forms a full complex product.
// - Real output sums all tap real products.
// - Imag output sums all tap imaginary products.
// - One slice holds two 9-bit taps.
// - One slice holds one 18-bit tap.
// - Two adders per slice, real one subtracts.
// - Slices chain for longer filters.
// - Slice results summed outside the slices.
// - Coefficients load serially or in parallel.
// - Coefficients change while filtering runs.
module complex_fir_filter (
    input  wire logic                                    clk_sys,
    input  wire logic                                    reset,
    input  wire logic                                    narrow_mode,
    input  wire logic                                    in_valid,
    input  wire logic signed [cfir_pkg::WORD_W_WIDE-1:0] in_re,
    input  wire logic signed [cfir_pkg::WORD_W_WIDE-1:0] in_im,
    input  wire logic                                    coef_ser_we,
    input  wire logic        [cfir_pkg::IDX_W-1:0]       coef_ser_idx,
    input  wire logic signed [cfir_pkg::WORD_W_WIDE-1:0] coef_ser_re,
    input  wire logic signed [cfir_pkg::WORD_W_WIDE-1:0] coef_ser_im,
    input  wire logic                                    coef_par_we,
    input  wire logic [cfir_pkg::NUM_TAPS*cfir_pkg::WORD_W_WIDE-1:0]
                                                         coef_par_re,
    input  wire logic [cfir_pkg::NUM_TAPS*cfir_pkg::WORD_W_WIDE-1:0]
                                                         coef_par_im,
    output logic                                         out_valid_q,
    output logic signed      [cfir_pkg::SUM_W-1:0]       out_re_q,
    output logic signed      [cfir_pkg::SUM_W-1:0]       out_im_q
);
    localparam int W = cfir_pkg::WORD_W_WIDE;
    localparam int T = cfir_pkg::NUM_TAPS;

    logic signed [W-1:0] xd_re_q [T];
    logic signed [W-1:0] xd_im_q [T];
    logic signed [W-1:0] xd_re_d [T];
    logic signed [W-1:0] xd_im_d [T];
    logic signed [W-1:0] h_re_q  [T];
    logic signed [W-1:0] h_im_q  [T];
    logic signed [W-1:0] h_re_d  [T];
    logic signed [W-1:0] h_im_d  [T];
    logic signed [cfir_pkg::PROD_W-1:0] p_re [T];
    logic signed [cfir_pkg::PROD_W-1:0] p_im [T];
    logic signed [cfir_pkg::SUM_W-1:0]  out_re_d;
    logic signed [cfir_pkg::SUM_W-1:0]  out_im_d;
    logic [cfir_pkg::LATENCY-3:0]       vpipe_q;
    logic [cfir_pkg::LATENCY-3:0]       vpipe_d;
    logic                               out_valid_d;

    // The delay line only advances on valid samples, so gaps in the input
    // stream do not insert zeros into the filter history.
    always_comb begin
        for (int i = 0; i < T; i++) begin
            xd_re_d[i] = xd_re_q[i];
            xd_im_d[i] = xd_im_q[i];
        end
        if (in_valid) begin
            xd_re_d[0] = in_re;
            xd_im_d[0] = in_im;
            for (int i = 1; i < T; i++) begin
                xd_re_d[i] = xd_re_q[i-1];
                xd_im_d[i] = xd_im_q[i-1];
            end
        end
    end

    // Parallel load takes priority over a serial write in the same cycle.
    always_comb begin
        for (int i = 0; i < T; i++) begin
            h_re_d[i] = h_re_q[i];
            h_im_d[i] = h_im_q[i];
        end
        if (coef_par_we) begin
            for (int i = 0; i < T; i++) begin
                h_re_d[i] = coef_par_re[i*W +: W];
                h_im_d[i] = coef_par_im[i*W +: W];
            end
        end else if (coef_ser_we) begin
            h_re_d[coef_ser_idx] = coef_ser_re;
            h_im_d[coef_ser_idx] = coef_ser_im;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < T; i++) begin
                xd_re_q[i] <= '0;
                xd_im_q[i] <= '0;
                h_re_q[i]  <= cfir_pkg::COEF_RESET;
                h_im_q[i]  <= cfir_pkg::COEF_RESET;
            end
        end else begin
            xd_re_q <= xd_re_d;
            xd_im_q <= xd_im_d;
            h_re_q  <= h_re_d;
            h_im_q  <= h_im_d;
        end
    end

    // One slice per delay-line position; more slices give more taps.
    for (genvar g = 0; g < T; g++) begin : g_slice
        cfir_slice u_slice (
            .clk_sys     (clk_sys),
            .reset       (reset),
            .narrow_mode (narrow_mode),
            .x_re        (xd_re_q[g]),
            .x_im        (xd_im_q[g]),
            .h_re        (h_re_q[g]),
            .h_im        (h_im_q[g]),
            .y_re_q      (p_re[g]),
            .y_im_q      (p_im[g])
        );
    end

    always_comb begin
        out_re_d = '0;
        out_im_d = '0;
        for (int i = 0; i < T; i++) begin
            out_re_d = out_re_d + cfir_pkg::SUM_W'(p_re[i]);
            out_im_d = out_im_d + cfir_pkg::SUM_W'(p_im[i]);
        end
    end

    // Valid: delay line (1), slice register (1), sum register (1),
    // plus this shift stage keeps the alignment with the data path.
    always_comb begin
        vpipe_d     = {vpipe_q[cfir_pkg::LATENCY-4:0], in_valid};
        out_valid_d = vpipe_q[cfir_pkg::LATENCY-3];
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            vpipe_q     <= '0;
            out_valid_q <= 1'b0;
            out_re_q    <= cfir_pkg::SUM_RESET;
            out_im_q    <= cfir_pkg::SUM_RESET;
        end else begin
            vpipe_q     <= vpipe_d;
            out_valid_q <= out_valid_d;
            out_re_q    <= out_re_d;
            out_im_q    <= out_im_d;
        end
    end

    AST_VALID_LATENCY: assert property (
        @(posedge clk_sys) disable iff (reset)
        in_valid |-> ##3 out_valid_q)
        else $error("Output valid missing three cycles after input.");

    AST_NO_SPURIOUS_VALID: assert property (
        @(posedge clk_sys) disable iff (reset)
        out_valid_q |-> $past(in_valid, 3))
        else $error("Output valid without matching input.");

    AST_PAR_LOAD: assert property (
        @(posedge clk_sys) disable iff (reset)
        coef_par_we |=> h_re_q[0] == $past(coef_par_re[W-1:0]))
        else $error("Parallel coefficient load not taken.");

    AST_SER_LOAD: assert property (
        @(posedge clk_sys) disable iff (reset)
        (coef_ser_we && !coef_par_we && coef_ser_idx == 2'h0)
        |=> h_im_q[0] == $past(coef_ser_im))
        else $error("Serial coefficient load not taken.");

    AST_WIDE_REAL: assert property (
        @(posedge clk_sys) disable iff (reset)
        !narrow_mode |=> p_re[0] == cfir_pkg::PROD_W'(
            $past(xd_re_q[0]) * $past(h_re_q[0])
          - $past(xd_im_q[0]) * $past(h_im_q[0])))
        else $error("Real slice product wrong.");

    AST_WIDE_IMAG: assert property (
        @(posedge clk_sys) disable iff (reset)
        !narrow_mode |=> p_im[0] == cfir_pkg::PROD_W'(
            $past(xd_re_q[0]) * $past(h_im_q[0])
          + $past(h_re_q[0]) * $past(xd_im_q[0])))
        else $error("Imaginary slice product wrong.");

    AST_SUM_REAL: assert property (
        @(posedge clk_sys) disable iff (reset)
        ##1 out_re_q == $past(cfir_pkg::SUM_W'(p_re[0]) + p_re[1]
                              + p_re[2] + p_re[3]))
        else $error("Real output sum wrong.");

    AST_SUM_IMAG: assert property (
        @(posedge clk_sys) disable iff (reset)
        ##1 out_im_q == $past(cfir_pkg::SUM_W'(p_im[0]) + p_im[1]
                              + p_im[2] + p_im[3]))
        else $error("Imaginary output sum wrong.");

    AST_HOLD_HISTORY: assert property (
        @(posedge clk_sys) disable iff (reset)
        !in_valid |=> $stable(xd_re_q[1]))
        else $error("Delay line moved without a sample.");

    AST_PAR_WINS: assert property (
        @(posedge clk_sys) disable iff (reset)
        (coef_par_we && coef_ser_we && coef_ser_idx == 2'h1)
        |=> h_im_q[1] == $past(coef_par_im[2*W-1:W]))
        else $error("Serial write beat a parallel load.");

    AST_LIVE_COEF: assert property (
        @(posedge clk_sys) disable iff (reset)
        (coef_ser_we && !coef_par_we)
        |=> h_re_q[$past(coef_ser_idx)] == $past(coef_ser_re))
        else $error("Serial coefficient write lost.");

    AST_VALID_PULSE: assert property (
        @(posedge clk_sys) disable iff (reset)
        !in_valid |-> ##3 !out_valid_q)
        else $error("Output valid without a sample three cycles before.");
endmodule

//--- bench/cfir_stream_partner.sv
/*
 * Stream partner of the complex FIR filter: sources samples upstream and
 * records every result downstream together with the cycle it was seen.
 * Assumes the bench calls send and idle from its own procedures.
 */
`timescale 1ns/1ps

module cfir_stream_partner (
    input  wire logic               clk_sys,
    input  wire logic               out_valid_q,
    input  wire logic signed [39:0] out_re_q,
    input  wire logic signed [39:0] out_im_q,
    output logic                    in_valid,
    output logic signed      [17:0] in_re,
    output logic signed      [17:0] in_im
);
    int          cyc = 0;
    int          sent_at[$];
    int          seen_at[$];
    logic [39:0] seen_re[$];
    logic [39:0] seen_im[$];

    initial begin
        in_valid = 1'b0;
        in_re = 18'h00000;
        in_im = 18'h00000;
    end

    // The consumer never stalls, since the filter offers no back-pressure.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (out_valid_q === 1'b1) begin
            seen_at.push_back(cyc);
            seen_re.push_back(out_re_q);
            seen_im.push_back(out_im_q);
        end
    end

    task automatic send(input logic [17:0] re, input logic [17:0] im);
        @(posedge clk_sys);
        #1;
        in_valid = 1'b1;
        in_re = re;
        in_im = im;
        sent_at.push_back(cyc);
    endtask

    // Released lines show the inverse of the last value, never a held copy.
    task automatic idle();
        @(posedge clk_sys);
        #1;
        in_valid = 1'b0;
        in_re = ~in_re;
        in_im = ~in_im;
    endtask
endmodule

//--- bench/complex_fir_filter_tb.sv
/*
 * Self-checking bench for complex_fir_filter: serial and parallel loads,
 * wide and narrow streams, judged against a model kept in this bench.
 * Assumes cfir_stream_partner sources samples and records all results.
 */
`timescale 1ns/1ps

module complex_fir_filter_tb;
    localparam int TAKE_TO_SEEN = 3;
    logic               clk_sys = 1'b0;
    logic               reset = 1'b1;
    logic               narrow_mode = 1'b0;
    logic               in_valid;
    logic signed [17:0] in_re;
    logic signed [17:0] in_im;
    logic               coef_ser_we = 1'b0;
    logic        [1:0]  coef_ser_idx = 2'h0;
    logic signed [17:0] coef_ser_re = 18'h00000;
    logic signed [17:0] coef_ser_im = 18'h00000;
    logic               coef_par_we = 1'b0;
    logic        [71:0] coef_par_re = 72'h0;
    logic        [71:0] coef_par_im = 72'h0;
    logic               out_valid_q;
    logic signed [39:0] out_re_q;
    logic signed [39:0] out_im_q;
    logic        [17:0] xr[4] = '{default: 18'h00000};
    logic        [17:0] xi[4] = '{default: 18'h00000};
    logic        [17:0] hr[4] = '{default: 18'h00000};
    logic        [17:0] hi[4] = '{default: 18'h00000};
    logic        [39:0] exp_re[$];
    logic        [39:0] exp_im[$];
    int                 err_total = 0;
    int                 num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    complex_fir_filter i_complex_fir_filter (.clk_sys, .reset, .narrow_mode,
        .in_valid, .in_re, .in_im, .coef_ser_we, .coef_ser_idx, .coef_ser_re,
        .coef_ser_im, .coef_par_we, .coef_par_re, .coef_par_im, .out_valid_q,
        .out_re_q, .out_im_q);
    cfir_stream_partner i_cfir_stream_partner (.clk_sys, .out_valid_q,
        .out_re_q, .out_im_q, .in_valid, .in_re, .in_im);

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(string what, logic [39:0] exp, logic [39:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Narrow mode splits each word into two signed 9-bit halves.
    function automatic logic signed [39:0] part(logic [17:0] v, int k);
        logic signed [8:0]  s9;
        logic signed [17:0] s18;
        s9 = v[9*k +: 9];
        s18 = v;
        if (narrow_mode) return s9;
        if (k == 0) return s18;
        return 40'sh0;
    endfunction

    task automatic push(logic [17:0] re, logic [17:0] im);
        logic signed [39:0] sr;
        logic signed [39:0] si;
        sr = 40'sh0;
        si = 40'sh0;
        for (int i = 3; i > 0; i--) begin
            xr[i] = xr[i-1];
            xi[i] = xi[i-1];
        end
        xr[0] = re;
        xi[0] = im;
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 2; k++) begin
                sr += part(xr[i],k)*part(hr[i],k)-part(xi[i],k)*part(hi[i],k);
                si += part(xr[i],k)*part(hi[i],k)+part(hr[i],k)*part(xi[i],k);
            end
        end
        exp_re.push_back(sr);
        exp_im.push_back(si);
        i_cfir_stream_partner.send(re, im);
    endtask

    task automatic stream(int n, logic [17:0] seed);
        logic [17:0] v;
        for (int j = 0; j < n; j++) begin
            v = seed + 18'(j) * 18'h0B3C5;
            push(v, ~v ^ 18'h15A5A);
        end
        i_cfir_stream_partner.idle();
    endtask

    task automatic drain();
        int t;
        t = 0;
        while (i_cfir_stream_partner.seen_re.size() < exp_re.size() && t < 12)
        begin
            @(posedge clk_sys);
            t++;
        end
        repeat (2) @(posedge clk_sys);
        check("count", 40'(exp_re.size()),
              40'(i_cfir_stream_partner.seen_re.size()));
        while (exp_re.size() > 0 && i_cfir_stream_partner.seen_re.size() > 0)
        begin
            check("real", exp_re.pop_front(),
                  i_cfir_stream_partner.seen_re.pop_front());
            check("imag", exp_im.pop_front(),
                  i_cfir_stream_partner.seen_im.pop_front());
            check("latency", 40'(TAKE_TO_SEEN),
                  40'(i_cfir_stream_partner.seen_at.pop_front() -
                      i_cfir_stream_partner.sent_at.pop_front()));
        end
        exp_re.delete();
        exp_im.delete();
    endtask

    task automatic load_ser(logic [71:0] vr, logic [71:0] vi);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            #1;
            coef_ser_we = 1'b1;
            coef_ser_idx = 2'(i);
            coef_ser_re = vr[18*i +: 18];
            coef_ser_im = vi[18*i +: 18];
            hr[i] = vr[18*i +: 18];
            hi[i] = vi[18*i +: 18];
        end
        @(posedge clk_sys);
        #1;
        coef_ser_we = 1'b0;
    endtask

    // A colliding serial write is sent too; the parallel load must win.
    task automatic load_par(logic [71:0] vr, logic [71:0] vi);
        @(posedge clk_sys);
        #1;
        coef_par_we = 1'b1;
        coef_par_re = vr;
        coef_par_im = vi;
        coef_ser_we = 1'b1;
        coef_ser_idx = 2'h1;
        coef_ser_re = ~vr[35:18];
        coef_ser_im = 18'h1FFFF;
        for (int i = 0; i < 4; i++) begin
            hr[i] = vr[18*i +: 18];
            hi[i] = vi[18*i +: 18];
        end
        @(posedge clk_sys);
        #1;
        coef_par_we = 1'b0;
        coef_ser_we = 1'b0;
    endtask

    task automatic test_wide_serial();
        load_ser(72'h80001FFFF3C0A5E712, 72'hFFFFC00007A5C3B10E);
        stream(6, 18'h20000);
        drain();
    endtask

    task automatic test_par_over();
        load_par(72'h0123456789ABCDEF01, 72'hFEDCBA9876543210FE);
        stream(5, 18'h1FFFF);
        drain();
    endtask

    // Coefficients change while older samples still sit in the delay line.
    task automatic test_live_change();
        stream(3, 18'h00001);
        load_ser(72'h3FFFF00002A5A5C3C3, 72'h1234500000FFFFF777);
        stream(3, 18'h3FFFF);
        drain();
    endtask

    task automatic test_narrow();
        @(posedge clk_sys);
        #1;
        narrow_mode = 1'b1;
        load_par(72'h80402010080402FF01, 72'h7FBFDFEFF7FBFD00FF);
        stream(6, 18'h20100);
        drain();
    endtask

    // Under a hundred cycles are needed; ten thousand means a hang.
    initial begin
        #100000;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        check("valid after reset", 40'h0, 40'(out_valid_q));
        check("real after reset", 40'h0, out_re_q);
        test_wide_serial();
        test_par_over();
        test_live_change();
        test_narrow();
        complete_run();
    end
endmodule
